// [twea_pkg.sv]
// Purpose: Shared constants and types for the two-wire EEPROM target
// Assumes: Reference clock of 25 MHz
// Notes:   Densities select strap comparison, page bits and page size
package twea_pkg;

	typedef enum logic [1:0] {
		TWEA_D2K,
		TWEA_D4K,
		TWEA_D8K,
		TWEA_D16K
	} twea_density_t;

	typedef enum logic [2:0] {
		TWEA_ST_IDLE,
		TWEA_ST_DEV,
		TWEA_ST_WADDR,
		TWEA_ST_WDATA,
		TWEA_ST_RDATA
	} twea_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} twea_line_t;

	// Device-type nibble of the address word
	localparam logic [3:0]  TWEA_DEV_TYPE     = 4'ha;
	// Address width of the smallest density
	localparam int          TWEA_ADDR_W_MIN   = 8;
	// Incrementing page bits: small density, then the others
	localparam int          TWEA_PAGE_W_SMALL = 3;
	localparam int          TWEA_PAGE_W       = 4;
	// Bit counter positions: last data bit and acknowledge slot
	localparam logic [3:0]  TWEA_BIT_LAST     = 4'h7;
	localparam logic [3:0]  TWEA_BIT_ACK      = 4'h8;
	localparam logic [3:0]  TWEA_BIT_RST      = 4'h0;
	localparam logic [10:0] TWEA_ADDR_RST     = 11'h000;
	localparam logic [2:0]  TWEA_STRAP_MASK   = 3'h7;
	localparam int          TWEA_CNT_W        = 18;
	// Nonvolatile program time
	localparam int          TWEA_REF_KHZ      = 25000;
	localparam int          TWEA_PROG_TIME_MS = 5;
	localparam int          TWEA_PROG_CYCLES  =
		TWEA_PROG_TIME_MS * TWEA_REF_KHZ;

endpackage

// [twea_target.sv]
// Purpose: Two-wire EEPROM target with address decode, writes and reads
// Assumes: link_clk oversamples scl and sda several times per bit
// Notes:   Bytes land in the array as they arrive; busy follows the stop
`timescale 1ns/100ps

module twea_target
	import twea_pkg::*;
#(
	parameter twea_density_t DENSITY     = TWEA_D2K,
	parameter int            PROG_CYCLES = TWEA_PROG_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic link_clk,
	input  wire logic scl,
	input  wire logic sda_in,
	input  wire logic strap_bit_high,
	input  wire logic strap_bit_mid,
	input  wire logic strap_bit_low,
	output logic      sda_out,
	output logic      sda_oe
);

	localparam int DW = TWEA_ADDR_W_MIN + int'(DENSITY);
	localparam int PW = (DENSITY == TWEA_D2K) ?
		TWEA_PAGE_W_SMALL : TWEA_PAGE_W;
	localparam int DEPTH = 1 << DW;
	localparam logic [DW-1:0] LOW = DW'((1 << PW) - 1);
	localparam logic [2:0] CMP_MASK =
		TWEA_STRAP_MASK << int'(DENSITY);
	localparam logic [TWEA_CNT_W-1:0] PROG_LOAD =
		TWEA_CNT_W'(PROG_CYCLES);
	localparam logic [TWEA_CNT_W-1:0] CNT_ONE = TWEA_CNT_W'(1);

	twea_line_t        l1;
	twea_line_t        l2;
	twea_line_t        l3;
	logic [2:0]        st1;
	logic [2:0]        st2;
	twea_state_t       state;
	logic [3:0]        bit_cnt;
	logic [7:0]        rx;
	logic [7:0]        tx;
	logic              rw;
	logic              mack;
	logic              first_fall;
	logic              wr_pend;
	logic [2:0]        dev_page;
	logic [DW-1:0]     addr;
	logic              req_tgl;
	logic              done1;
	logic              done2;
	logic              req1;
	logic              req2;
	logic              done_tgl;
	logic [TWEA_CNT_W-1:0] prog_cnt;
	logic [7:0]        mem [0:DEPTH-1];

	wire logic         scl_rise;
	wire logic         scl_fall;
	wire logic         start;
	wire logic         stop;
	wire logic         busy;
	wire logic         dev_ok;
	wire logic         ack_edge;
	wire logic         end_ack;
	wire logic         load_rd;
	wire logic [10:0]  word_full;
	wire logic [DW-1:0] waddr;
	wire logic [DW-1:0] addr_wr_next;
	wire logic [DW-1:0] addr_rd_next;
	wire logic [7:0]   rd_byte;
	wire logic         prog_start;

	// Pins are asynchronous to link_clk; l1 and st1 feed only l2 and st2
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			l1  <= '1;
			l2  <= '1;
			l3  <= '1;
			st1 <= 3'h0;
			st2 <= 3'h0;
		end else begin
			l1  <= '{scl: scl, sda: sda_in};
			l2  <= l1;
			l3  <= l2;
			st1 <= {strap_bit_high, strap_bit_mid, strap_bit_low};
			st2 <= st1;
		end
	end

	assign scl_rise = l2.scl & ~l3.scl;
	assign scl_fall = ~l2.scl & l3.scl;
	assign start    = l2.scl & l3.scl & l3.sda & ~l2.sda;
	assign stop     = l2.scl & l3.scl & ~l3.sda & l2.sda;

	// Busy spans from the write stop until the reference side echoes back
	assign busy   = req_tgl ^ done2;
	assign dev_ok = (rx[7:4] == TWEA_DEV_TYPE) &&
		(((rx[3:1] ^ st2) & CMP_MASK) == 3'h0) &&
		!busy;

	// Page bits sit above the received word address byte
	assign word_full    = {dev_page, rx};
	assign waddr        = word_full[DW-1:0];
	assign addr_wr_next = (addr & ~LOW) | ((addr + 1'b1) & LOW);
	assign addr_rd_next = addr + 1'b1;
	assign rd_byte      = mem[addr];

	assign ack_edge = scl_fall && (bit_cnt == TWEA_BIT_LAST);
	assign end_ack  = scl_fall && (bit_cnt == TWEA_BIT_ACK);
	assign load_rd  = end_ack &&
		(((state == TWEA_ST_DEV) && rw) ||
		((state == TWEA_ST_RDATA) && mack));

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// A start aborts any transfer in flight but keeps a pending write, which is how recovery works
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= TWEA_ST_IDLE;
			bit_cnt  <= TWEA_BIT_RST;
			rx       <= 8'h00;
			tx       <= 8'h00;
			rw       <= 1'b0;
			mack     <= 1'b0;
			wr_pend  <= 1'b0;
			dev_page <= 3'h0;
			addr     <= TWEA_ADDR_RST[DW-1:0];
			req_tgl  <= 1'b0;
			sda_oe   <= 1'b0;
			first_fall <= 1'b0;
		end else if (start) begin
			state   <= TWEA_ST_DEV;
			bit_cnt <= TWEA_BIT_RST;
			first_fall <= 1'b1;
			sda_oe  <= 1'b0;
		end else if (stop) begin
			state   <= TWEA_ST_IDLE;
			sda_oe  <= 1'b0;
			wr_pend <= 1'b0;
			if (wr_pend) begin
				req_tgl <= ~req_tgl;
			end
		end else if (state == TWEA_ST_IDLE) begin
			sda_oe <= 1'b0;
		end else if (scl_rise) begin
			if (bit_cnt < TWEA_BIT_ACK && state != TWEA_ST_RDATA) begin
				rx <= {rx[6:0], l2.sda};
			end
			if (bit_cnt == TWEA_BIT_ACK) begin
				mack <= ~l2.sda;
			end
		end else if (ack_edge) begin
			bit_cnt <= TWEA_BIT_ACK;
			unique case (state)
				TWEA_ST_DEV: begin
					if (dev_ok) begin
						sda_oe   <= 1'b1;
						dev_page <= rx[3:1];
						rw       <= rx[0];
					end else begin
						state <= TWEA_ST_IDLE;
					end
				end
				TWEA_ST_WADDR: begin
					sda_oe <= 1'b1;
					addr   <= waddr;
				end
				TWEA_ST_WDATA: begin
					sda_oe  <= 1'b1;
					addr    <= addr_wr_next;
					wr_pend <= 1'b1;
				end
				TWEA_ST_RDATA: begin
					sda_oe <= 1'b0;
				end
				TWEA_ST_IDLE: begin
					sda_oe <= 1'b0;
				end
			endcase
		end else if (end_ack) begin
			bit_cnt <= TWEA_BIT_RST;
			if (load_rd) begin
				state  <= TWEA_ST_RDATA;
				tx     <= rd_byte;
				sda_oe <= ~rd_byte[7];
				addr   <= addr_rd_next;
			end else begin
				sda_oe <= 1'b0;
				unique case (state)
					TWEA_ST_DEV: begin
						state <= TWEA_ST_WADDR;
					end
					TWEA_ST_WADDR: begin
						state <= TWEA_ST_WDATA;
					end
					TWEA_ST_WDATA: begin
						state <= TWEA_ST_WDATA;
					end
					TWEA_ST_RDATA: begin
						state <= TWEA_ST_IDLE;
					end
					TWEA_ST_IDLE: begin
						state <= TWEA_ST_IDLE;
					end
				endcase
			end
		end else if (scl_fall) begin
			// The fall that closes a start is not a data bit
			first_fall <= 1'b0;
			if (!first_fall) begin
				bit_cnt <= bit_cnt + 1'b1;
			end
			if (state == TWEA_ST_RDATA) begin
				sda_oe <= ~tx[6];
				tx     <= {tx[6:0], 1'b0};
			end
		end
	end

	// Array has no reset: its content is meant to outlive any reset
	always_ff @(posedge link_clk) begin
		if (ack_edge && state == TWEA_ST_WDATA) begin
			mem[addr] <= rx;
		end
	end

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			done1 <= 1'b0;
			done2 <= 1'b0;
		end else begin
			done1 <= done_tgl;
			done2 <= done1;
		end
	end

	// Toggle handshake: reference side answers each request exactly once
	assign prog_start = (req2 ^ done_tgl) && (prog_cnt == '0);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			req1     <= 1'b0;
			req2     <= 1'b0;
			done_tgl <= 1'b0;
			prog_cnt <= '0;
		end else begin
			req1 <= req_tgl;
			req2 <= req1;
			if (prog_start) begin
				prog_cnt <= PROG_LOAD;
			end else if (prog_cnt != '0) begin
				prog_cnt <= prog_cnt - CNT_ONE;
			end
			if (prog_cnt == CNT_ONE) begin
				done_tgl <= ~done_tgl;
			end
		end
	end

	ack_on_match_a: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		(state == TWEA_ST_DEV && ack_edge && dev_ok && !start && !stop)
		|=> sda_oe ##1 sda_oe)
		else $error("Matching address not acknowledged");

	nack_mismatch_a: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		(state == TWEA_ST_DEV && ack_edge && !dev_ok && !start && !stop)
		|=> (state == TWEA_ST_IDLE) && !sda_oe)
		else $error("Mismatched address not dropped");

	busy_no_ack_a: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		busy |-> !(sda_oe && state == TWEA_ST_DEV))
		else $error("Acknowledge given while programming");

	dev_type_a: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		(rx[7:4] != TWEA_DEV_TYPE) |-> !dev_ok)
		else $error("Wrong device type accepted");

	dir_select_a: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		(state == TWEA_ST_DEV && end_ack && !start && !stop)
		|=> (state == (rw ? TWEA_ST_RDATA : TWEA_ST_WADDR)))
		else $error("Direction bit not obeyed");

	page_hold_a: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		(state == TWEA_ST_WDATA && ack_edge && !start && !stop)
		|=> ((addr & ~LOW) == ($past(addr) & ~LOW)) &&
		((addr & LOW) == (($past(addr) + 1'b1) & LOW)))
		else $error("Write address left its page");

	read_incr_a: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		(load_rd && !start && !stop)
		|=> (addr == $past(addr) + 1'b1) && (tx == mem[$past(addr)]))
		else $error("Read counter not advanced");

	start_seen_a: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		start |=> (state == TWEA_ST_DEV) && (bit_cnt == TWEA_BIT_RST))
		else $error("Start not taken");

	start_fall_a: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		(first_fall && scl_fall && state != TWEA_ST_IDLE && !start && !stop)
		|=> (bit_cnt == TWEA_BIT_RST) && !first_fall)
		else $error("Start clock fall counted as a bit");

	stop_idle_a: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		(stop && !start) |=> (state == TWEA_ST_IDLE) && !sda_oe)
		else $error("Stop did not return to idle");

	busy_after_a: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		(stop && wr_pend) |=> busy)
		else $error("Write stop did not start programming");

	prog_load_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		prog_start |=> (prog_cnt == PROG_LOAD) ##1 (prog_cnt < PROG_LOAD))
		else $error("Program timer not loaded");

	write_cov_c: cover property (
		@(posedge link_clk) disable iff (!rst_n)
		(stop && wr_pend));

	seq_read_c: cover property (
		@(posedge link_clk) disable iff (!rst_n)
		(load_rd && state == TWEA_ST_RDATA));

	poll_nack_c: cover property (
		@(posedge link_clk) disable iff (!rst_n)
		(state == TWEA_ST_DEV && ack_edge && busy));

	prog_done_c: cover property (
		@(posedge ref_clk) disable iff (!rst_n)
		(prog_cnt == CNT_ONE));

endmodule

// [twea_host.sv]
// Purpose: Two-wire bus controller model facing the EEPROM target
// Assumes: Pulled-up data line; one bus phase per ref_clk cycle
// Notes:   Driving sda high means releasing it to the pull-up
`timescale 1ns/100ps

module twea_host (
	input  wire logic ref_clk,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda
);
	// Bus idles high and scl stands still between frames
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// Works from idle and as a repeated start
	task automatic start();
		@(negedge ref_clk) sda = 1'b1;
		@(negedge ref_clk) scl = 1'b1;
		@(negedge ref_clk) sda = 1'b0;
		@(negedge ref_clk) scl = 1'b0;
	endtask

	// Ends a write or read frame
	task automatic stop();
		@(negedge ref_clk) sda = 1'b0;
		@(negedge ref_clk) scl = 1'b1;
		@(negedge ref_clk) sda = 1'b1;
	endtask

	// Data moves only while scl is low, so no false start or stop
	task automatic bit_x(input logic b, output logic r);
		@(negedge ref_clk) sda = b;
		@(negedge ref_clk) scl = 1'b1;
		@(negedge ref_clk) r = sda_wire;
		scl = 1'b0;
	endtask

	// MSB first, then ninth clock; last low acks a read byte
	task automatic xfer(input logic [7:0] w, input logic last,
		output logic [7:0] r, output logic a);
		int i;
		for (i = 7; i >= 0; i--) begin
			bit_x(w[i], r[i]);
		end
		bit_x(last, a);
	endtask

	// Clocks a stuck target up to nine times until sda is high; starts only if it freed
	task automatic recover(output logic ok);
		int n;
		ok = 1'b0;
		for (n = 0; n < 9 && !ok; n++) begin
			@(negedge ref_clk) sda = 1'b1;
			@(negedge ref_clk) scl = 1'b1;
			@(negedge ref_clk) ok = sda_wire;
			if (!ok)
				scl = 1'b0;
		end
		@(negedge ref_clk) sda = 1'b0;
		@(negedge ref_clk) scl = 1'b0;
	endtask
endmodule

// [two_wire_eeprom_access_tb.sv]
// Purpose: Self-checking bench for the two-wire EEPROM target
// Assumes: 2K density, straps 101, shortened program cycle
// Notes:   Controller model drives the bus; tasks judge the replies
`timescale 1ns/100ps

module two_wire_eeprom_access_tb;
	import twea_pkg::*;

	localparam logic [7:0] DEV_W = 8'haa;
	localparam logic [7:0] DEV_R = 8'hab;
	localparam logic [7:0] RD_EXP [5] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h39};

	logic       ref_clk = 1'b0;
	logic       link_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [2:0] strap = 3'h5;
	logic       scl;
	logic       sda;
	logic       sda_out;
	logic       sda_oe;
	logic       ack;
	logic [7:0] rd;
	int         err_total = 0;
	int         n_compared = 0;
	// Pull-up: the wire is low only where some party pulls it
	wire        sda_wire = sda & ~(sda_oe & ~sda_out);

	always #20 ref_clk = ~ref_clk;
	// Offset keeps link edges clear of ref_clk edges
	always begin
		if ($time == 0)
			#1.7;
		#3 link_clk = ~link_clk;
	end

	// Short program time so a poll can land inside it
	twea_target #(.DENSITY(TWEA_D2K), .PROG_CYCLES(60)) i_twea_target (
		.ref_clk        (ref_clk),
		.rst_n          (rst_n),
		.link_clk       (link_clk),
		.scl            (scl),
		.sda_in         (sda_wire),
		.strap_bit_high (strap[2]),
		.strap_bit_mid  (strap[1]),
		.strap_bit_low  (strap[0]),
		.sda_out        (sda_out),
		.sda_oe         (sda_oe)
	);

	twea_host i_twea_host (
		.ref_clk  (ref_clk),
		.sda_wire (sda_wire),
		.scl      (scl),
		.sda      (sda)
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic snd(input logic [7:0] w, input logic nak);
		i_twea_host.xfer(w, 1'b1, rd, ack);
		chk({7'h0, ack}, {7'h0, nak});
	endtask

	task automatic rcv(input logic last, input logic [7:0] exp);
		i_twea_host.xfer(8'hff, last, rd, ack);
		chk(rd, exp);
	endtask

	// Acknowledged read polls are closed with a no-ack byte so the stop is clean
	task automatic wait_done();
		logic a;
		int   n;
		a = 1'b1;
		n = 0;
		while (a !== 1'b0 && n < 20) begin
			i_twea_host.start();
			i_twea_host.xfer(DEV_R, 1'b1, rd, a);
			if (a === 1'b0)
				i_twea_host.xfer(8'hff, 1'b1, rd, ack);
			i_twea_host.stop();
			n++;
		end
		chk({7'h0, a}, 8'h00);
	endtask

	// Ten bytes into an 8-byte page: the last two overwrite the first two
	task automatic t_page_write();
		int k;
		i_twea_host.start();
		snd(DEV_W, 1'b0);
		snd(8'h16, 1'b0);
		for (k = 0; k < 10; k++) begin
			snd(8'h30 + 8'(k), 1'b0);
		end
		i_twea_host.stop();
		i_twea_host.start();
		snd(DEV_R, 1'b1);
		i_twea_host.stop();
		wait_done();
		$display("page write test done");
	endtask

	task automatic t_refuse();
		i_twea_host.start();
		snd(8'hba, 1'b1);
		i_twea_host.start();
		snd(8'ha3, 1'b1);
		i_twea_host.stop();
		$display("refusal test done");
	endtask

	// Abandon a read mid-byte, clock the target free, then address it
	task automatic t_recover();
		logic ok;
		i_twea_host.start();
		snd(DEV_R, 1'b0);
		i_twea_host.recover(ok);
		chk({7'h0, ok}, 8'h01);
		snd(DEV_W, 1'b0);
		i_twea_host.stop();
		$display("recovery test done");
	endtask

	task automatic t_read();
		int k;
		i_twea_host.start();
		snd(DEV_W, 1'b0);
		snd(8'h13, 1'b0);
		i_twea_host.start();
		snd(DEV_R, 1'b0);
		for (k = 0; k < 4; k++) begin
			rcv(k == 3, RD_EXP[k]);
		end
		i_twea_host.stop();
		i_twea_host.start();
		snd(DEV_R, 1'b0);
		rcv(1'b1, RD_EXP[4]);
		i_twea_host.stop();
		$display("read test done");
	endtask

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk) rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		t_page_write();
		t_refuse();
		t_recover();
		t_read();
		stop_test();
	end

	// Whole run needs about 1000 cycles; a hang is cut well after that
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		stop_test();
	end
endmodule
